// ===== design/ppt_pkg.sv
// ppt_pkg: constants, enumerations and carrier structs of the prescaled period timer.
// assumes: 32-bit AXI4-Lite register access, one clock domain, inputs synchronous to it.
package ppt_pkg;

    // register bus geometry
    localparam int          ADDR_W = 12;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    // register indices; the byte address is four times the index
    localparam logic [11:0] IDX_COUNT      = 12'h190;
    localparam logic [11:0] IDX_PERIOD     = 12'h192;
    localparam logic [11:0] IDX_CONTROL    = 12'h194;
    localparam logic [11:0] IDX_IRQ_STATUS = 12'h1f0;
    localparam logic [11:0] IDX_IRQ_MASK   = 12'h1f1;
    localparam logic [11:0] ADDR_COUNT      = {IDX_COUNT[9:0], 2'b00};
    localparam logic [11:0] ADDR_PERIOD     = {IDX_PERIOD[9:0], 2'b00};
    localparam logic [11:0] ADDR_CONTROL    = {IDX_CONTROL[9:0], 2'b00};
    localparam logic [11:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS[9:0], 2'b00};
    localparam logic [11:0] ADDR_IRQ_MASK   = {IDX_IRQ_MASK[9:0], 2'b00};

    // control register field positions
    localparam int CTL_RUN_BIT  = 15;
    localparam int CTL_IDLE_BIT = 13;
    localparam int CTL_ECS_LSB  = 8;
    localparam int CTL_GATE_BIT = 6;
    localparam int CTL_PSC_LSB  = 4;
    localparam int CTL_SYNC_BIT = 2;
    localparam int CTL_SRC_BIT  = 1;
    localparam logic [15:0] CTL_WMASK = 16'ha376;

    // values after reset
    localparam logic [15:0] COUNT_RST   = 16'h0000;
    localparam logic [15:0] PERIOD_RST  = 16'h0000;
    localparam logic [15:0] CONTROL_RST = 16'h0000;

    // interrupt status and mask layout
    localparam int IRQ_W         = 2;
    localparam int IRQ_MATCH_BIT = 0;
    localparam int IRQ_GATE_BIT  = 1;

    // prescaler terminal counts, ratio minus one
    localparam logic [7:0] PSC_TC_1   = 8'h00;
    localparam logic [7:0] PSC_TC_8   = 8'h07;
    localparam logic [7:0] PSC_TC_64  = 8'h3f;
    localparam logic [7:0] PSC_TC_256 = 8'hff;

    typedef enum logic [1:0] {
        EXT_SEC_OSC       = 2'b00,
        EXT_DEDICATED_PIN = 2'b01,
        EXT_LOW_POWER_RC  = 2'b10,
        EXT_GENERIC_PIN   = 2'b11
    } ppt_ext_e;

    typedef enum logic [1:0] {
        PSC_DIV1   = 2'b00,
        PSC_DIV8   = 2'b01,
        PSC_DIV64  = 2'b10,
        PSC_DIV256 = 2'b11
    } ppt_psc_e;

    // decoded control register
    typedef struct packed {
        logic     run_enable;
        logic     idle_stop;
        ppt_ext_e ext_source_select;
        logic     gate_accumulate_enable;
        ppt_psc_e prescale_select;
        logic     ext_sync_enable;
        logic     source_select;
    } ppt_ctl_s;

    // external clock inputs, bit index equals the source code
    typedef struct packed {
        logic generic_timer_clock_pin;
        logic low_power_rc_osc;
        logic dedicated_clock_pin;
        logic secondary_osc;
    } ppt_ext_pins_s;

endpackage : ppt_pkg

// ===== design/ppt_clk_front.sv
// ppt_clk_front: source select, optional synchroniser, gate and prescaler of the timer.
// assumes: pins sampled on aclk; run and psc_clr come from the timer core.
`timescale 1ns/1ps
`default_nettype none
module ppt_clk_front
    import ppt_pkg::*;
(
    // clock, reset, enable
    input  wire  logic          aclk,
    input  wire  logic          aresetn,
    input  wire  logic          ce,
    // control from the core
    input  wire  ppt_ctl_s      ctl,
    input  wire  logic          run,
    input  wire  logic          psc_clr,
    // pins
    input  wire  ppt_ext_pins_s ext_pins,
    input  wire  logic          gate_pin,
    // events
    output logic                tick,
    output logic                gate_fall
);

    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       sync3;
        logic       raw_prev;
        logic       gate_now;
        logic       gate_prev;
        logic [7:0] psc_cnt;
        logic       tick;
        logic       gate_fall;
    } ppt_front_s;

    ppt_front_s st_q;
    ppt_front_s st_d;
    logic [3:0] ext_vec;

    assign ext_vec = ext_pins;

    // edge pick, gating and division in one pass
    always_comb begin
        logic       ext_lvl;
        logic       ext_edge;
        logic       src_pulse;
        logic [7:0] tc;
        ext_lvl   = 1'b0;
        ext_edge  = 1'b0;
        src_pulse = 1'b0;
        tc        = PSC_TC_1;
        st_d      = st_q;
        ext_lvl   = ext_vec[ctl.ext_source_select];
        // sync1 feeds only sync2, so a metastable level never reaches the edge logic
        st_d.sync1    = ext_lvl;
        st_d.sync2    = st_q.sync1;
        st_d.sync3    = st_q.sync2;
        st_d.raw_prev = ext_lvl;
        st_d.gate_now  = gate_pin;
        st_d.gate_prev = st_q.gate_now;
        // the sync bit only matters on the external path
        ext_edge = ctl.ext_sync_enable ? (st_q.sync2 & ~st_q.sync3)
                                       : (ext_lvl & ~st_q.raw_prev);
        if (ctl.source_select) begin
            src_pulse = ext_edge;                             // gate ignored here
        end else begin
            src_pulse = ctl.gate_accumulate_enable ? st_q.gate_now : 1'b1;
        end
        st_d.gate_fall = run & ~ctl.source_select & ctl.gate_accumulate_enable
                         & st_q.gate_prev & ~st_q.gate_now;
        case (ctl.prescale_select)
            PSC_DIV1:   tc = PSC_TC_1;
            PSC_DIV8:   tc = PSC_TC_8;
            PSC_DIV64:  tc = PSC_TC_64;
            PSC_DIV256: tc = PSC_TC_256;
            default:    tc = PSC_TC_1;
        endcase
        st_d.tick = 1'b0;
        if (psc_clr) begin
            st_d.psc_cnt = 8'h00;
        end else if (run && src_pulse) begin
            if (st_q.psc_cnt >= tc) begin
                st_d.psc_cnt = 8'h00;
                st_d.tick    = 1'b1;
            end else begin
                st_d.psc_cnt = 8'(st_q.psc_cnt + 8'h01);
            end
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign tick      = st_q.tick;
    assign gate_fall = st_q.gate_fall;

    chk_psc_clear_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && psc_clr |=> st_q.psc_cnt == 8'h00) else $error("prescaler not cleared");
    chk_psc_div_one: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && run && !psc_clr && !ctl.source_select && !ctl.gate_accumulate_enable
        && ctl.prescale_select == PSC_DIV1 |=> st_q.tick) else $error("div1 tick missing");

endmodule : ppt_clk_front
`default_nettype wire

// ===== design/ppt_timer.sv
// ppt_timer: 16-bit prescaled period timer with AXI4-Lite registers and a level interrupt.
// assumes: single AXI4-Lite master, aclk at 100 MHz, idle and sleep levels from power control.
//
// Functional notes
// - count register is 16-bit read/write, zero at reset, writable any time.
// - period register is 16-bit read/write terminal count, zero at reset.
// - run_enable bit 15 starts counting when one, stops when zero.
// - control write while running clears prescaler; software should avoid it.
// - idle_stop bit 13 halts timer in idle mode, else keeps running.
// - ext_source_select 9:8 picks generic pin, rc osc, dedicated pin, secondary osc.
// - gate bit 6 enables gated accumulation on internal clock; ignored on external.
// - prescale_select 5:4 divides by 256, 64, 8 or 1.
// - ext_sync_enable bit 2 synchronises the external clock, else used directly.
// - sync bit is ignored whenever the internal clock is selected.
// - source_select bit 1 picks external source when one, internal clock when zero.
// - interrupt flag on period match, or on gate falling edge in gated mode.
// - timer may keep running in idle and sleep as timer or counter; here only an unsynchronised external count runs in sleep.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module ppt_timer
    import ppt_pkg::*;
(
    // clock, reset, enable
    input  wire  logic              aclk,
    input  wire  logic              aresetn,
    input  wire  logic              ce,
    // axi4-lite write address
    input  wire  logic [ADDR_W-1:0] awaddr,
    input  wire  logic [2:0]        awprot,
    input  wire  logic              awvalid,
    output logic                    awready,
    // axi4-lite write data
    input  wire  logic [31:0]       wdata,
    input  wire  logic [3:0]        wstrb,
    input  wire  logic              wvalid,
    output logic                    wready,
    // axi4-lite write response
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire  logic              bready,
    // axi4-lite read address
    input  wire  logic [ADDR_W-1:0] araddr,
    input  wire  logic [2:0]        arprot,
    input  wire  logic              arvalid,
    output logic                    arready,
    // axi4-lite read data
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire  logic              rready,
    // power state
    input  wire  logic              idle_mode,
    input  wire  logic              sleep_mode,
    // timer pins
    input  wire  ppt_ext_pins_s     ext_pins,
    input  wire  logic              gate_pin,
    // interrupt
    output logic                    irq
);

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
        logic              aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_have;
        logic [15:0]       w_data;
        logic [1:0]        w_strb;
        logic [15:0]       count;
        logic [15:0]       period;
        ppt_ctl_s          ctl;
        logic [IRQ_W-1:0]  status;
        logic [IRQ_W-1:0]  mask;
        logic              irq;
        logic              psc_clr;
    } ppt_top_s;

    ppt_top_s st_q;
    ppt_top_s st_d;

    logic        tick;
    logic        gate_fall;
    logic        do_wr;
    logic        wr_count;
    logic        wr_period;
    logic        wr_ctl;
    logic        wr_status;
    logic        wr_mask;
    logic        wr_mapped;
    logic [15:0] wmask16;
    logic        async_ext;
    logic        run_now;
    logic        match;

    // pack the control struct into its register image, reserved bits zero
    function automatic logic [15:0] ctl_pack(input ppt_ctl_s c);
        logic [15:0] v;
        v = 16'h0000;
        v[CTL_RUN_BIT]              = c.run_enable;
        v[CTL_IDLE_BIT]             = c.idle_stop;
        v[CTL_ECS_LSB+1:CTL_ECS_LSB] = c.ext_source_select;
        v[CTL_GATE_BIT]             = c.gate_accumulate_enable;
        v[CTL_PSC_LSB+1:CTL_PSC_LSB] = c.prescale_select;
        v[CTL_SYNC_BIT]             = c.ext_sync_enable;
        v[CTL_SRC_BIT]              = c.source_select;
        return v;
    endfunction : ctl_pack

    // unpack a register image; only implemented bits are taken
    function automatic ppt_ctl_s ctl_unpack(input logic [15:0] v);
        ppt_ctl_s c;
        c.run_enable             = v[CTL_RUN_BIT];
        c.idle_stop              = v[CTL_IDLE_BIT];
        c.ext_source_select      = ppt_ext_e'(v[CTL_ECS_LSB+1:CTL_ECS_LSB]);
        c.gate_accumulate_enable = v[CTL_GATE_BIT];
        c.prescale_select        = ppt_psc_e'(v[CTL_PSC_LSB+1:CTL_PSC_LSB]);
        c.ext_sync_enable        = v[CTL_SYNC_BIT];
        c.source_select          = v[CTL_SRC_BIT];
        return c;
    endfunction : ctl_unpack

    // read multiplexer; narrow registers sit in the low bits
    function automatic logic [32:0] read_mux(input logic [ADDR_W-1:0] a, input ppt_top_s s);
        logic [32:0] r;
        r = {1'b0, 32'h0000_0000};
        case (a)
            ADDR_COUNT:      r = {1'b0, 16'h0000, s.count};
            ADDR_PERIOD:     r = {1'b0, 16'h0000, s.period};
            ADDR_CONTROL:    r = {1'b0, 16'h0000, ctl_pack(s.ctl)};
            ADDR_IRQ_STATUS: r = {1'b0, 30'h0000_0000, s.status};
            ADDR_IRQ_MASK:   r = {1'b0, 30'h0000_0000, s.mask};
            default:         r = {1'b1, 32'h0000_0000};
        endcase
        return r;
    endfunction : read_mux

    // prescaler and clock front end
    ppt_clk_front u_front (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .ctl       (st_q.ctl),
        .run       (run_now),
        .psc_clr   (st_q.psc_clr),
        .ext_pins  (ext_pins),
        .gate_pin  (gate_pin),
        .tick      (tick),
        .gate_fall (gate_fall)
    );

    // write decode; a write happens once address and data are both held
    assign do_wr     = st_q.aw_have & st_q.w_have & ~st_q.bvalid;
    assign wmask16   = {{8{st_q.w_strb[1]}}, {8{st_q.w_strb[0]}}};
    assign wr_count  = do_wr & (st_q.aw_addr == ADDR_COUNT);
    assign wr_period = do_wr & (st_q.aw_addr == ADDR_PERIOD);
    assign wr_ctl    = do_wr & (st_q.aw_addr == ADDR_CONTROL);
    assign wr_status = do_wr & (st_q.aw_addr == ADDR_IRQ_STATUS);
    assign wr_mask   = do_wr & (st_q.aw_addr == ADDR_IRQ_MASK);
    assign wr_mapped = wr_count | wr_period | wr_ctl | wr_status | wr_mask;

    // run qualification: only an unsynchronised external count survives sleep,
    // since the internal clock and the synchroniser are treated as stopped there
    assign async_ext = st_q.ctl.source_select & ~st_q.ctl.ext_sync_enable;
    assign run_now   = st_q.ctl.run_enable
                       & ~(st_q.ctl.idle_stop & idle_mode)
                       & ~(sleep_mode & ~async_ext);
    assign match     = tick & run_now & (st_q.count == st_q.period);

    // next state of registers, counter and bus channels
    always_comb begin
        logic [32:0]      rd;
        logic [15:0]      ctl_img;
        logic [IRQ_W-1:0] ev_set;
        logic [IRQ_W-1:0] ev_clr;
        rd      = {1'b0, 32'h0000_0000};
        ctl_img = 16'h0000;
        ev_set  = '0;
        ev_clr  = '0;
        st_d    = st_q;
        st_d.psc_clr = 1'b0;

        // capture address and data independently, in either order
        if (awvalid && st_q.awready) begin
            st_d.aw_have = 1'b1;
            st_d.aw_addr = awaddr;
        end
        if (wvalid && st_q.wready) begin
            st_d.w_have = 1'b1;
            st_d.w_data = wdata[15:0];
            st_d.w_strb = wstrb[1:0];
        end

        // counting, a software write of the count below takes precedence
        if (tick && run_now) begin
            st_d.count = match ? COUNT_RST : 16'(st_q.count + 16'h0001);
        end
        if (wr_count) begin
            st_d.count = (st_q.count & ~wmask16) | (st_q.w_data & wmask16);
        end
        if (wr_period) begin
            st_d.period = (st_q.period & ~wmask16) | (st_q.w_data & wmask16);
        end
        if (wr_ctl) begin
            ctl_img = (ctl_pack(st_q.ctl) & ~wmask16) | (st_q.w_data & wmask16);
            st_d.ctl = ctl_unpack(ctl_img & CTL_WMASK);
            st_d.psc_clr = st_q.ctl.run_enable;
        end
        if (wr_mask) begin
            st_d.mask = (st_q.mask & ~wmask16[IRQ_W-1:0]) | (st_q.w_data[IRQ_W-1:0]
                        & wmask16[IRQ_W-1:0]);
        end

        // sticky events; a set in the clearing cycle wins
        ev_set[IRQ_MATCH_BIT] = match;
        ev_set[IRQ_GATE_BIT]  = gate_fall;
        if (wr_status) begin
            ev_clr = st_q.w_data[IRQ_W-1:0] & wmask16[IRQ_W-1:0];
        end
        st_d.status = (st_q.status & ~ev_clr) | ev_set;

        // write response
        if (do_wr) begin
            st_d.aw_have = 1'b0;
            st_d.w_have  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        if (st_q.bvalid && bready) begin
            st_d.bvalid = 1'b0;
        end
        // hold off new beats until the previous write has been answered
        st_d.awready = ~st_d.aw_have & ~st_d.bvalid;
        st_d.wready  = ~st_d.w_have & ~st_d.bvalid;

        // read channel, one read in flight
        if (arvalid && st_q.arready) begin
            rd          = read_mux(araddr, st_q);
            st_d.rvalid = 1'b1;
            st_d.rdata  = rd[31:0];
            st_d.rresp  = rd[32] ? RESP_SLVERR : RESP_OKAY;
        end else if (st_q.rvalid && rready) begin
            st_d.rvalid = 1'b0;
        end
        st_d.arready = ~st_d.rvalid;

        st_d.irq = |(st_d.status & st_d.mask);
    end

    // one register for all state; ce low freezes everything
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // every output straight from the state register
    assign awready = st_q.awready;
    assign wready  = st_q.wready;
    assign bvalid  = st_q.bvalid;
    assign bresp   = st_q.bresp;
    assign arready = st_q.arready;
    assign rvalid  = st_q.rvalid;
    assign rdata   = st_q.rdata;
    assign rresp   = st_q.rresp;
    assign irq     = st_q.irq;

    // checks on the timer core
    default clocking ppt_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_reset_clears_regs: assert property (
        $rose(aresetn) |-> st_q.count == COUNT_RST && st_q.period == PERIOD_RST
        && ctl_pack(st_q.ctl) == CONTROL_RST) else $error("registers not cleared by reset");

    chk_count_increment: assert property (
        ce && tick && run_now && !match && !wr_count
        |=> st_q.count == 16'($past(st_q.count) + 16'h0001)) else $error("count did not step");

    chk_count_wrap_zero: assert property (
        ce && match && !wr_count |=> st_q.count == 16'h0000 && st_q.status[IRQ_MATCH_BIT])
        else $error("no wrap or flag on match");

    chk_stopped_holds: assert property (
        ce && !st_q.ctl.run_enable && !wr_count |=> $stable(st_q.count))
        else $error("count moved while stopped");

    chk_idle_halts: assert property (
        ce && st_q.ctl.idle_stop && idle_mode && !wr_count |=> $stable(st_q.count))
        else $error("count moved in idle with stop set");

    chk_ctl_reserved_zero: assert property (
        (ctl_pack(st_q.ctl) & ~CTL_WMASK) == 16'h0000) else $error("reserved control bits set");

    chk_run_write_clears: assert property (
        ce && wr_ctl && st_q.ctl.run_enable |=> st_q.psc_clr)
        else $error("prescaler clear missing on running write");

    chk_irq_follows_mask: assert property (
        st_q.irq == |(st_q.status & st_q.mask)) else $error("irq not status and mask");

    chk_status_sticky: assert property (
        ce && st_q.status[IRQ_MATCH_BIT] && !wr_status |=> st_q.status[IRQ_MATCH_BIT])
        else $error("status lost without clear");

    chk_write_answer: assert property (
        ce && do_wr |=> st_q.bvalid) else $error("no write response");

    cov_period_match: cover property (ce && match);
    cov_gate_fall_evt: cover property (ce && gate_fall);
    cov_running_write: cover property (ce && wr_ctl && st_q.ctl.run_enable);
    cov_read_answer: cover property (st_q.rvalid && rready);

endmodule : ppt_timer
`default_nettype wire

// ===== dv/ppt_timer_tb_top.sv
// ppt_timer_tb_top: register-level bench of the prescaled period timer.
// assumes: ppt_pkg compiled first; one aclk domain; the bench drives all pins itself.
`timescale 1ns/1ps
`default_nettype none
module ppt_timer_tb_top import ppt_pkg::*;;
    logic              aclk      = 1'b0;
    logic              aresetn   = 1'b0;
    logic              awvalid   = 1'b0;
    logic              wvalid    = 1'b0;
    logic              bready    = 1'b0;
    logic              arvalid   = 1'b0;
    logic              rready    = 1'b0;
    logic              idle_mode = 1'b0;
    logic              gate_pin  = 1'b0;
    logic              sleep_mode = 1'b0;
    logic [ADDR_W-1:0] awaddr    = 12'h000;
    logic [ADDR_W-1:0] araddr    = 12'h000;
    logic [31:0]       wdata     = 32'h0;
    ppt_ext_pins_s     ext_pins  = 4'h0;
    logic              awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]        bresp, rresp, bs, rs;
    logic [31:0]       rdata, rd;
    int                fails = 0, n_compared = 0, cyc = 0, ex;
    int                sh[4] = '{0, 3, 6, 8};

    // prot is not decoded by the block and strobes are held all ones, so they stay constant
    ppt_timer uut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .idle_mode(idle_mode),
        .sleep_mode(sleep_mode), .ext_pins(ext_pins), .gate_pin(gate_pin), .irq(irq));

    // 100 MHz clock
    always #5 aclk = ~aclk;

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    // a hang in any handshake wait ends here
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    task automatic cmp_rng(input logic [31:0] got, input int lo, input int hi);
        n_compared++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            fails++;
            $display("unexpected at %0t: got %h range %h %h", $time, got, lo, hi);
        end
    endtask : cmp_rng

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic aw_open;
        logic w_open;
        aw_open = 1'b1;
        w_open  = 1'b1;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (aw_open || w_open) begin
            @(posedge aclk);
            aw_open = aw_open && (awready !== 1'b1);
            w_open  = w_open && (wready !== 1'b1);
            awvalid <= aw_open;
            wvalid  <= w_open;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bs = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd_reg(input logic [11:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd_reg

    task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp);
        rd_reg(a);
        cmp(rd, exp);
    endtask : chk_rd

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        // values after reset, then access kinds of control, count and period
        chk_rd(ADDR_COUNT, 32'h0);
        chk_rd(ADDR_PERIOD, 32'h0);
        chk_rd(ADDR_CONTROL, 32'h0);
        chk_rd(ADDR_IRQ_STATUS, 32'h0);
        chk_rd(ADDR_IRQ_MASK, 32'h0);
        wr(ADDR_CONTROL, 32'h5c89);
        chk_rd(ADDR_CONTROL, 32'h0);
        wr(ADDR_CONTROL, 32'hffff_7f76);
        chk_rd(ADDR_CONTROL, 32'h2376);
        wr(ADDR_COUNT, 32'hffff_1234);
        chk_rd(ADDR_COUNT, 32'h1234);
        cmp(bs, RESP_OKAY);
        wr(ADDR_PERIOD, 32'h0000_beef);
        chk_rd(ADDR_PERIOD, 32'hbeef);
        wr(12'h004, 32'h1);
        cmp(bs, RESP_SLVERR);
        rd_reg(12'h004);
        cmp(rs, RESP_SLVERR);
        cmp(rd, 32'h0);
        // period 5: count never passes it and the match flag reaches irq
        wr(ADDR_PERIOD, 32'h5);
        wr(ADDR_COUNT, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h1);
        wr(ADDR_CONTROL, 32'h8000);
        for (int i = 0; i < 8; i++) begin
            rd_reg(ADDR_COUNT);
            cmp_rng(rd, 0, 5);
        end
        cmp(irq, 1'b1);
        wr(ADDR_CONTROL, 32'h0);
        rd_reg(ADDR_COUNT);
        chk_rd(ADDR_COUNT, rd);
        chk_rd(ADDR_IRQ_STATUS, 32'h1);
        wr(ADDR_IRQ_MASK, 32'h0);
        cmp(irq, 1'b0);
        wr(ADDR_IRQ_MASK, 32'h3);
        cmp(irq, 1'b1);
        wr(ADDR_IRQ_STATUS, 32'h1);
        cmp(irq, 1'b0);
        chk_rd(ADDR_IRQ_STATUS, 32'h0);
        // each prescale code over a fixed window; bus latency gives the slack
        wr(ADDR_PERIOD, 32'hffff);
        for (int p = 0; p < 4; p++) begin
            wr(ADDR_COUNT, 32'h0);
            wr(ADDR_CONTROL, 32'h8000 | (p << 4));
            repeat (1024) @(posedge aclk);
            wr(ADDR_CONTROL, 32'h0);
            rd_reg(ADDR_COUNT);
            ex = 1024 >> sh[p];
            cmp_rng(rd, ex - 1, ex + 8);
        end
        // rewrites closer than eight cycles keep the divide-by-8 from ticking
        wr(ADDR_COUNT, 32'h0);
        for (int i = 0; i < 12; i++) wr(ADDR_CONTROL, 32'h8010);
        wr(ADDR_CONTROL, 32'h0);
        chk_rd(ADDR_COUNT, 32'h0);
        // each external source, gate set but low, sync on odd codes;
        // the unsynchronised ones run in sleep, where they must keep counting
        for (int k = 0; k < 4; k++) begin
            sleep_mode <= (k % 2 == 0);
            wr(ADDR_COUNT, 32'h0);
            wr(ADDR_CONTROL, 32'h8042 | (k << 8) | ((k & 1) << 2));
            repeat (10) begin
                ext_pins[k] <= 1'b1;
                repeat (3) @(posedge aclk);
                ext_pins[k] <= 1'b0;
                repeat (3) @(posedge aclk);
            end
            repeat (4) @(posedge aclk);
            wr(ADDR_CONTROL, 32'h0);
            chk_rd(ADDR_COUNT, 32'd10);
        end
        // internal clock counts nothing while asleep
        sleep_mode <= 1'b1;
        wr(ADDR_COUNT, 32'h0);
        wr(ADDR_CONTROL, 32'h8000);
        repeat (20) @(posedge aclk);
        wr(ADDR_CONTROL, 32'h0);
        sleep_mode <= 1'b0;
        chk_rd(ADDR_COUNT, 32'h0);
        // gated internal clock with the sync bit set, which must not matter
        wr(ADDR_COUNT, 32'h0);
        wr(ADDR_CONTROL, 32'h8044);
        repeat (5) @(posedge aclk);
        gate_pin <= 1'b1;
        repeat (20) @(posedge aclk);
        gate_pin <= 1'b0;
        repeat (5) @(posedge aclk);
        cmp(irq, 1'b1);
        wr(ADDR_CONTROL, 32'h0);
        chk_rd(ADDR_COUNT, 32'd20);
        chk_rd(ADDR_IRQ_STATUS, 32'h2);
        // idle halts only with idle_stop set
        wr(ADDR_COUNT, 32'h0);
        idle_mode <= 1'b1;
        wr(ADDR_CONTROL, 32'ha000);
        repeat (50) @(posedge aclk);
        chk_rd(ADDR_COUNT, 32'h0);
        wr(ADDR_CONTROL, 32'h8000);
        repeat (50) @(posedge aclk);
        wr(ADDR_CONTROL, 32'h0);
        rd_reg(ADDR_COUNT);
        cmp_rng(rd, 50, 70);
        give_verdict();
    end
endmodule : ppt_timer_tb_top
`default_nettype wire
